// ### common/ref_monitor_defines.vh
// constants for the reference monitor mask and status register bank
// assumes a 32-bit ahb-lite slave with one register per aligned word
`ifndef REF_MONITOR_DEFINES_VH
`define REF_MONITOR_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_LOOP_EVENT_ENABLE  6'h0b
`define IDX_ALARM_ENABLE_A     6'h0c
`define IDX_ALARM_ENABLE_B     6'h0d
`define IDX_ALARM_ENABLE_C     6'h0e
`define IDX_RATE_A             6'h10
`define IDX_LOOP_EVENT_STATUS  6'h18
`define IDX_INPUT_FAIL_STATUS  6'h19
`define IDX_BYTE_LSB           2
`define IDX_BYTE_MSB           7

// reset values
`define RST_LOOP_EVENT_ENABLE  4'h0
`define RST_ALARM_ENABLE       8'hff
`define RST_ALARM_RSVD         4'hf
`define RST_ALARM_ENABLE_C     4'hf
`define RST_EVENT_STATUS       4'h0

// loop event bit positions
`define EV_LOCKED              0
`define EV_LOST_LOCK           1
`define EV_HOLDOVER            2
`define EV_REF_CHANGED         3
`define EV_W                   4

// monitor positions inside one nibble
`define MON_SINGLE_CYCLE       0
`define MON_COARSE_FREQ        1
`define MON_GUARD_SOAK         2
`define MON_PRECISE_FREQ       3
`define MON_W                  4
`define INPUTS                 5

// detected rate code
`define RATE_W                 4
`define RATE_UNKNOWN           4'hf
`define RATE_MAX               4'ha

// ahb-lite
`define HTRANS_NONSEQ_BIT      1
`define HRESP_OKAY             1'b0
`define DATA_W                 32

`endif

// ### dv/ref_monitor_mask_status_regs_tb.sv
// self-checking bench for the mask and status register bank
// assumes the slave is alone on the bus, hready from hreadyout
module ref_monitor_mask_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [19:0] mon_fail = 0;
  logic [3:0]  loop_event = 0;
  logic [3:0]  r0 = 0;
  logic [3:0]  r1 = 0;
  logic        v0 = 0;
  logic        v1 = 0;
  logic [31:0] q;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         irq;
  wire  [4:0]  input_failed;
  int          bad_count = 0;
  int          checks = 0;
  int          i;
  ref_monitor_mask_status_regs dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mon_fail(mon_fail), .loop_event(loop_event),
    .input0_rate_in(r0), .input0_rate_valid(v0),
    .input1_rate_in(r1), .input1_rate_valid(v1),
    .input_failed(input_failed), .irq(irq));
  initial forever #2 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (checks > 0 && bad_count == 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cmp(input string n, input [31:0] e, input [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // bounded wait for hready; a hang ends the run
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 9);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      end_of_test;
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    q = hrdata;
  endtask
  task rd(input [31:0] a, input [31:0] e, input string n);
    xfer(0, a, 0);
    cmp(n, e, q);
  endtask
  task tk;
    repeat (2) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    rd(32'h2c, 0, "enable");
    rd(32'h30, 32'hff, "alarm_a");
    rd(32'h34, 32'hff, "alarm_b");
    rd(32'h38, 32'hff, "alarm_c");
    rd(32'h40, 32'hff, "rate");
    rd(32'h00, 0, "unmapped");
    xfer(1, 32'h38, 0);
    rd(32'h38, 32'hf0, "alarm_c");
    // input 4 now masked, so its monitors must stay silent
    for (i = 0; i < 20; i++) begin
      mon_fail <= 20'h1 << i;
      tk;
      cmp("failed", (i < 16) ? 32'h1 << (i / 4) : 0, input_failed);
    end
    xfer(1, 32'h30, 32'h12);
    mon_fail <= 20'h00012;
    tk;
    cmp("failed", 3, input_failed);
    mon_fail <= 20'h00021;
    tk;
    cmp("failed", 0, input_failed);
    xfer(1, 32'h34, 32'h5a);
    rd(32'h34, 32'h5a, "alarm_b");
    mon_fail <= 20'h05a00;
    tk;
    cmp("failed", 32'h0c, input_failed);
    rd(32'h64, 32'h0c, "fail_status");
    v1 <= 1;
    r1 <= 4'h3;
    for (i = 0; i < 16; i++) begin
      r0 <= i;
      v0 <= 1;
      rd(32'h40, {4'h3, (i > 10) ? 4'hf : 4'(i)}, "rate");
    end
    v1 <= 0;
    r0 <= 4'h2;
    xfer(1, 32'h40, 0);
    rd(32'h40, 32'hf2, "rate");
    for (i = 0; i < 4; i++) begin
      loop_event <= 4'h1 << i;
      @(posedge hclk);
      loop_event <= 0;
      tk;
      cmp("irq", 0, irq);
      rd(32'h60, 32'h1 << i, "status");
      xfer(1, 32'h2c, 32'h1 << i);
      tk;
      cmp("irq", 1, irq);
      xfer(1, 32'h60, 32'h1 << i);
      tk;
      cmp("irq", 0, irq);
      rd(32'h60, 0, "status");
      xfer(1, 32'h2c, 0);
    end
    // an event standing through the clear keeps its flag
    loop_event <= 4'h8;
    xfer(1, 32'h60, 32'h8);
    rd(32'h60, 32'h8, "status");
    loop_event <= 0;
    xfer(1, 32'h60, 32'h8);
    rd(32'h60, 0, "status");
    end_of_test;
  end
endmodule // ref_monitor_mask_status_regs_tb

// ### dv/ref_monitor_regs_props.sv
// assertions on the mask and status register bank ports
// assumes one slave, so hready is the slave's own hreadyout
module regs_props (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // monitors and events
  input wire [19:0] mon_fail,
  input wire [3:0]  loop_event,
  input wire [4:0]  input_failed,
  input wire        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && htrans[1] && hready;
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  ////////////////////////////////////////////////////////////////////
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  read_wait_a: assert property (take && !hwrite |=> rd_wait)
    else $error("read wait wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  ready_idle_a: assert property (!take && hreadyout |=> hreadyout)
    else $error("stall without request");
  rdata_high_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  fail_clear_a: assert property (mon_fail == 0 |=> input_failed == 0)
    else $error("failure without monitor");
  // irq may only move after an event or a committed write
  irq_rise_a: assert property ($rose(irq) |->
    $past(loop_event) != 0 || $past(hwrite, 2))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |->
    $past(hwrite) || $past(hwrite, 2))
    else $error("irq fell without write");
endmodule // regs_props

bind ref_monitor_mask_status_regs regs_props chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mon_fail(mon_fail),
  .loop_event(loop_event), .input_failed(input_failed), .irq(irq));

// ### src/ref_monitor_mask_status_regs.v
// reference monitor mask and status registers behind an ahb-lite slave
// assumes monitors, loop and rate detector sit in the same hclk domain
`include "ref_monitor_defines.vh"

module ref_monitor_mask_status_regs (
  // clock and reset
  input  wire                     hclk,
  input  wire                     hresetn,
  // ahb-lite slave
  input  wire                     hsel,
  input  wire [31:0]              haddr,
  input  wire [1:0]               htrans,
  input  wire                     hwrite,
  input  wire [2:0]               hsize,
  input  wire [`DATA_W-1:0]       hwdata,
  input  wire                     hready,
  output reg  [`DATA_W-1:0]       hrdata,
  output reg                      hreadyout,
  output reg                      hresp,
  // monitor failure levels, nibble per input
  input  wire [`INPUTS*`MON_W-1:0] mon_fail,
  // receive loop event pulses
  input  wire [`EV_W-1:0]         loop_event,
  // rate detector results for inputs 0 and 1
  input  wire [`RATE_W-1:0]       input0_rate_in,
  input  wire                     input0_rate_valid,
  input  wire [`RATE_W-1:0]       input1_rate_in,
  input  wire                     input1_rate_valid,
  // results
  output reg  [`INPUTS-1:0]       input_failed,
  output reg                      irq
);

  ////////////////////////////////////////////////////////////////////////
  // bus capture

  reg                      wr_pend_q;
  reg                      rd_pend_q;
  reg  [5:0]               idx_q;
  wire                     accept;
  wire [5:0]               idx_in;

  assign accept = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
  assign idx_in = haddr[`IDX_BYTE_MSB:`IDX_BYTE_LSB];

  // address phase capture; the index is held for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q     <= 6'h00;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= accept & hwrite;
      if (accept) begin
        idx_q <= idx_in;
      end
    end
  end

  // reads take one wait state so a read right after a write sees it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
      end
      if (accept && !hwrite) begin
        rd_pend_q <= 1'b1;
        hreadyout <= 1'b0;
      end
    end
  end

  // no error responses exist in this slave
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `HRESP_OKAY;
    end else begin
      hresp <= `HRESP_OKAY;
    end
  end

  wire wr_commit;
  assign wr_commit = wr_pend_q;

  ////////////////////////////////////////////////////////////////////////
  // write strobes, one per writable register

  wire              we_loop_enable;
  wire              we_alarm_a;
  wire              we_alarm_b;
  wire              we_alarm_c;
  wire              we_event_status;

  assign we_loop_enable  = wr_commit && (idx_q == `IDX_LOOP_EVENT_ENABLE);
  assign we_alarm_a      = wr_commit && (idx_q == `IDX_ALARM_ENABLE_A);
  assign we_alarm_b      = wr_commit && (idx_q == `IDX_ALARM_ENABLE_B);
  assign we_alarm_c      = wr_commit && (idx_q == `IDX_ALARM_ENABLE_C);
  assign we_event_status = wr_commit && (idx_q == `IDX_LOOP_EVENT_STATUS);

  ////////////////////////////////////////////////////////////////////////
  // control registers

  reg  [`EV_W-1:0]  loop_enable_q;
  reg  [7:0]        alarm_en_a_q;
  reg  [7:0]        alarm_en_b_q;
  reg  [3:0]        alarm_en_c_q;

  // interrupt enables come up cleared so nothing fires before setup
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_enable_q <= `RST_LOOP_EVENT_ENABLE;
    end else if (we_loop_enable) begin
      loop_enable_q <= hwdata[`EV_W-1:0];
    end
  end

  // alarm enables come up open so every failure counts until masked
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_en_a_q <= `RST_ALARM_ENABLE;
    end else if (we_alarm_a) begin
      alarm_en_a_q <= hwdata[7:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_en_b_q <= `RST_ALARM_ENABLE;
    end else if (we_alarm_b) begin
      alarm_en_b_q <= hwdata[7:0];
    end
  end

  // upper nibble reserved: not stored, reads back as its default
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_en_c_q <= `RST_ALARM_ENABLE_C;
    end else if (we_alarm_c) begin
      alarm_en_c_q <= hwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // monitor gating

  wire [`INPUTS*`MON_W-1:0] alarm_enable;
  wire [`INPUTS-1:0]        failed_d;

  // nibble order: input0 .. input4
  assign alarm_enable = {alarm_en_c_q, alarm_en_b_q, alarm_en_a_q};

  genvar gi;
  generate
    for (gi = 0; gi < `INPUTS; gi = gi + 1) begin : g_gate
      nibble_alarm_gate #(
        .W (`MON_W)
      ) gate_u (
        .fail   (mon_fail[gi*`MON_W +: `MON_W]),
        .enable (alarm_enable[gi*`MON_W +: `MON_W]),
        .failed (failed_d[gi])
      );
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_failed <= {`INPUTS{1'b0}};
    end else begin
      input_failed <= failed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loop event status and interrupt

  wire [`EV_W-1:0] ev_status_q;
  wire [`EV_W-1:0] ev_clear;
  wire [`EV_W-1:0] ev_status_d;

  assign ev_clear = we_event_status ? hwdata[`EV_W-1:0] : {`EV_W{1'b0}};

  genvar ei;
  generate
    for (ei = 0; ei < `EV_W; ei = ei + 1) begin : g_event
      sticky_event_bit event_u (
        .clk    (hclk),
        .rst_n  (hresetn),
        .set    (loop_event[ei]),
        .clear  (ev_clear[ei]),
        .flag_d (ev_status_d[ei]),
        .flag_q (ev_status_q[ei])
      );
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      // next status, so a fresh event raises irq with its own flag
      irq <= |(ev_status_d & loop_enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // detected rate codes

  wire [`RATE_W-1:0] rate0_q;
  wire [`RATE_W-1:0] rate1_q;

  rate_code_capture #(
    .W   (`RATE_W),
    .MAX (`RATE_MAX),
    .UNK (`RATE_UNKNOWN)
  ) rate0_u (
    .clk     (hclk),
    .rst_n   (hresetn),
    .code_in (input0_rate_in),
    .valid   (input0_rate_valid),
    .code_q  (rate0_q)
  );

  rate_code_capture #(
    .W   (`RATE_W),
    .MAX (`RATE_MAX),
    .UNK (`RATE_UNKNOWN)
  ) rate1_u (
    .clk     (hclk),
    .rst_n   (hresetn),
    .code_in (input1_rate_in),
    .valid   (input1_rate_valid),
    .code_q  (rate1_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // read data

  reg [7:0] rd_byte;

  always @* begin
    case (idx_q)
      `IDX_LOOP_EVENT_ENABLE: rd_byte = {4'h0, loop_enable_q};
      `IDX_ALARM_ENABLE_A:    rd_byte = alarm_en_a_q;
      `IDX_ALARM_ENABLE_B:    rd_byte = alarm_en_b_q;
      `IDX_ALARM_ENABLE_C:    rd_byte = {`RST_ALARM_RSVD, alarm_en_c_q};
      `IDX_RATE_A:            rd_byte = {rate1_q, rate0_q};
      `IDX_LOOP_EVENT_STATUS: rd_byte = {4'h0, ev_status_q};
      `IDX_INPUT_FAIL_STATUS: rd_byte = {3'h0, input_failed};
      default:                rd_byte = 8'h00;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= {`DATA_W{1'b0}};
    end else if (rd_pend_q) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

endmodule // ref_monitor_mask_status_regs

////////////////////////////////////////////////////////////////////////////
// one input's monitor nibble against its enable nibble

module nibble_alarm_gate #(
  parameter W = `MON_W
) (
  // monitor levels and enables
  input  wire [W-1:0] fail,
  input  wire [W-1:0] enable,
  // gated result
  output wire         failed
);

  // zero in the enable nibble keeps that monitor out
  assign failed = |(fail & enable);

endmodule // nibble_alarm_gate

////////////////////////////////////////////////////////////////////////////
// one sticky event flag, cleared by writing a one

module sticky_event_bit (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // event and software clear
  input  wire set,
  input  wire clear,
  // next and held flag
  output wire flag_d,
  output reg  flag_q
);

  // set wins over a clear in the same cycle so no event is lost
  assign flag_d = set | (flag_q & ~clear);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule // sticky_event_bit

////////////////////////////////////////////////////////////////////////////
// registered rate code with out-of-table values folded to unknown

module rate_code_capture #(
  parameter         W   = `RATE_W,
  parameter [W-1:0] MAX = `RATE_MAX,
  parameter [W-1:0] UNK = `RATE_UNKNOWN
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // detector result
  input  wire [W-1:0] code_in,
  input  wire         valid,
  // held code
  output reg  [W-1:0] code_q
);

  // codes above the table read as not yet detected, so software never
  // sees a value it cannot decode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= UNK;
    end else begin
      code_q <= (valid && code_in <= MAX) ? code_in : UNK;
    end
  end

endmodule // rate_code_capture
